// >>> pkg/ipc_pkg.sv
// shared constants and carrier types of the instruction prefetch cache
package ipc_pkg;
    // buffer geometry
    localparam int BUF_BYTES = 128;
    localparam int BUF_WORDS = 32;
    localparam int SLOT_W = 5;
    localparam int HALF_IDX_W = 6;
    localparam int SLOT_LSB = 2;
    localparam int SLOT_MSB = 6;
    localparam int HALF_LSB = 1;
    // prefetch pipeline and look-ahead limits
    localparam logic [1:0] MAX_PEND = 2'h2;
    localparam logic [29:0] AHEAD_LIMIT = 30'h8;
    localparam logic [31:0] WORD_STEP = 32'h4;
    localparam logic [29:0] FWD_REACH_WORDS = 30'h2;
    localparam logic [5:0] HALF_STEP = 6'h1;
    // status word field and reset values
    localparam int SR_M_BIT = 4;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic RESET_M = 1'b0;

    // request toward the memory access pipeline
    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } ipc_fetch_t;

    // taken branch reported by the execution stage
    typedef struct packed {
        logic taken;
        logic one_half;
        logic delayed;
        logic [31:0] target;
    } ipc_branch_t;

    // decoder view of the current instruction
    typedef struct packed {
        logic ready;
        logic [47:0] halves;
    } ipc_dec_t;
endpackage

// >>> core/ipc_inflight.sv
// two-entry queue of word addresses whose prefetch bus cycle is in flight
`timescale 1ns/10ps
module ipc_inflight
    import ipc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic [31:0] i_addr,
    input wire logic i_pop,
    output logic [1:0] o_count,
    output logic [31:0] o_head
);
    logic [31:0] q_r [0:1];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;

    // storage needs no reset, only the pointers define what is live
    always_ff @(posedge i_mclk) begin
        if (i_push) begin
            q_r[wr_ptr_r] <= i_addr;
        end
    end

    // pointers and occupancy; the caller never pushes into a full queue
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (i_push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (i_pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= 2'(count_r + {1'b0, i_push} - {1'b0, i_pop});
        end
    end

    assign o_count = count_r;
    assign o_head = q_r[rd_ptr_r];
endmodule

// >>> core/ipc_core.sv
// instruction prefetch cache: circular word buffer, prefetch control, decode read
`timescale 1ns/10ps

module ipc_core
    import ipc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    output ipc_fetch_t o_fetch,
    input wire logic i_fetch_gnt,
    input wire logic i_fetch_rvalid,
    input wire logic [31:0] i_fetch_rdata,
    input wire logic [31:0] i_pc,
    input wire logic [1:0] i_instr_len,
    input wire ipc_branch_t i_branch,
    input wire logic i_frame_exec,
    input wire logic i_mem_exec,
    input wire logic i_sr_wr,
    input wire logic [31:0] i_sr_wdata,
    output ipc_dec_t o_dec,
    output logic o_cache_mode,
    output logic [31:0] o_look_ahead,
    output logic [31:0] o_look_back
);
    logic [31:0] buf_r [0:BUF_WORDS-1];
    logic [31:0] la_r;
    logic [31:0] lb_r;
    logic [31:0] ret_r;
    logic first_r;
    logic loaded_r;
    logic req_r;
    logic [31:0] addr_r;
    logic [1:0] drop_r;
    logic m_r;
    ipc_dec_t dec_r;

    logic issue;
    logic keep;
    logic [1:0] pend;
    logic [31:0] head;
    logic [31:0] la_nxt;
    logic first_nxt;
    logic [1:0] pend_nxt;
    logic [29:0] ahead;
    logic room;
    logic fetch_ok;
    logic [31:0] addr_nxt;
    logic [31:0] tgt_w;
    logic [29:0] tw;
    logic fwd;
    logic in_cache;
    logic hold;
    logic flush;
    logic [31:0] last_half;
    logic avail_first;
    logic avail_last;
    logic [HALF_IDX_W-1:0] h0;
    logic [HALF_IDX_W-1:0] h1;
    logic [HALF_IDX_W-1:0] h2;

    // addresses of words whose bus cycle is open, oldest first
    ipc_inflight u_inflight (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_push(issue),
        .i_addr(addr_r),
        .i_pop(i_fetch_rvalid),
        .o_count(pend),
        .o_head(head)
    );

    // word present between look-back and last returned word
    // both offsets are taken from the look-back word, so the compare stays correct
    // when the window straddles the top of the address space
    // a word that is granted but not yet returned counts as missing here:
    // decode must wait for the data, not only for the bus cycle
    function automatic logic word_avail(input logic [29:0] w, input logic [29:0] lbw,
                                        input logic [29:0] rw, input logic ld);
        logic [29:0] off;
        logic [29:0] span;
        off = 30'(w - lbw);
        span = 30'(rw - lbw);
        word_avail = ld && (off <= span);
    endfunction

    // big-endian half word: even index is the high half of its word
    function automatic logic [15:0] half_at(input logic [HALF_IDX_W-1:0] idx,
                                            input logic [31:0] word);
        half_at = idx[0] ? word[15:0] : word[31:16];
    endfunction

    // issue bookkeeping as it will stand after this edge
    always_comb begin
        issue = req_r & i_fetch_gnt;
        keep = i_fetch_rvalid & (drop_r == 2'h0);
        la_nxt = issue ? addr_r : la_r;
        first_nxt = first_r & ~issue;
        pend_nxt = 2'(pend + {1'b0, issue} - {1'b0, i_fetch_rvalid});
    end

    // look-ahead distance counts pending words too, since la covers them
    always_comb begin
        ahead = 30'(la_nxt[31:2] - i_pc[31:2]);
        room = first_nxt | ahead[29] | (ahead < AHEAD_LIMIT);
        fetch_ok = room & ~i_mem_exec & (pend_nxt < MAX_PEND) & ~flush;
        addr_nxt = first_nxt ? la_nxt : 32'(la_nxt + WORD_STEP);
    end

    // branch target check for one-half-word branches
    // direction is judged against the pc word; a target in the pc word counts as forward
    // the two words past look-ahead are usually fetched while the branch executes,
    // so treating them as present costs at most a few wait cycles
    // a delayed forward one-half-word branch with the mode flag set never flushes; decode
    // then waits until prefetch reaches the target
    always_comb begin
        tgt_w = {i_branch.target[31:2], 2'b00};
        tw = i_branch.target[31:2];
        fwd = tw >= i_pc[31:2];
        // forward reach includes two words past the look-ahead word
        in_cache = fwd ? (tw <= 30'(la_r[31:2] + FWD_REACH_WORDS)) : (tw >= lb_r[31:2]);
        hold = i_branch.one_half & (in_cache | (i_branch.delayed & m_r & fwd));
        flush = i_branch.taken & ~hold;
    end

    // decode-side availability of first and last half word
    always_comb begin
        h0 = i_pc[SLOT_MSB:HALF_LSB];
        h1 = 6'(h0 + HALF_STEP);
        h2 = 6'(h1 + HALF_STEP);
        last_half = 32'(i_pc + {29'h0, i_instr_len - 2'h1, 1'b0});
        avail_first = word_avail(i_pc[31:2], lb_r[31:2], ret_r[31:2], loaded_r);
        avail_last = word_avail(last_half[31:2], lb_r[31:2], ret_r[31:2], loaded_r);
    end

    // fill the slot chosen when the word was issued; one-hot write per slot
    for (genvar s = 0; s < BUF_WORDS; s++) begin : g_slot
        always_ff @(posedge i_mclk) begin
            if (keep && head[SLOT_MSB:SLOT_LSB] == SLOT_W'(s)) begin
                buf_r[s] <= i_fetch_rdata;
            end
        end
    end

    // look-ahead counter and flush restart
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            la_r <= RESET_PC;
            first_r <= 1'b1;
        end else if (flush) begin
            la_r <= tgt_w;
            first_r <= 1'b1;
        end else begin
            la_r <= la_nxt;
            first_r <= first_nxt;
        end
    end

    // look-back counter reloads on a flush, otherwise only moves when its slot is overwritten
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lb_r <= RESET_PC;
        end else if (flush) begin
            lb_r <= tgt_w;
        end else if (keep && head[SLOT_MSB:SLOT_LSB] == lb_r[SLOT_MSB:SLOT_LSB]
                     && head[31:2] != lb_r[31:2]) begin
            lb_r <= 32'(lb_r + WORD_STEP);
        end
    end

    // highest returned word; stale returns after a flush are discarded
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ret_r <= RESET_PC;
            loaded_r <= 1'b0;
        end else if (flush) begin
            loaded_r <= 1'b0;
        end else if (keep) begin
            ret_r <= head;
            loaded_r <= 1'b1;
        end
    end

    // words still owed from before a flush; they must not enter the buffer
    // the count includes a grant taken in the flush cycle itself, which is why
    // it is loaded from the bookkeeping after this edge
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drop_r <= 2'h0;
        end else if (flush) begin
            drop_r <= pend_nxt;
        end else if (i_fetch_rvalid && drop_r != 2'h0) begin
            drop_r <= 2'(drop_r - 2'h1);
        end
    end

    // request toward memory; may be withdrawn before grant if a halt arises
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_r <= 1'b0;
            addr_r <= RESET_PC;
        end else if (flush) begin
            // restart at the target at once when the pipeline has a free stage and no memory cycle runs
            req_r <= (pend_nxt < MAX_PEND) & ~i_mem_exec;
            addr_r <= tgt_w;
        end else begin
            req_r <= fetch_ok;
            addr_r <= addr_nxt;
        end
    end

    // cache-mode flag: software write wins over the hardware clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            m_r <= RESET_M;
        end else if (i_sr_wr) begin
            m_r <= i_sr_wdata[SR_M_BIT];
        end else if (i_frame_exec || (i_branch.taken && !i_branch.delayed)) begin
            m_r <= 1'b0;
        end
    end

    // decode read is registered; ready low means insert a wait cycle
    // three halves are always read; the decoder ignores those past its length
    // ready is forced low in the flush cycle since the window is being rebuilt
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dec_r <= '0;
        end else begin
            dec_r.ready <= avail_first & avail_last & ~flush;
            dec_r.halves <= {half_at(h0, buf_r[h0[5:1]]),
                             half_at(h1, buf_r[h1[5:1]]),
                             half_at(h2, buf_r[h2[5:1]])};
        end
    end

    assign o_fetch.req = req_r;
    assign o_fetch.addr = addr_r;
    assign o_dec = dec_r;
    assign o_cache_mode = m_r;
    assign o_look_ahead = la_r;
    assign o_look_back = lb_r;
endmodule

// >>> tb/ipc_mem_model.sv
// memory pipeline model answering prefetch requests in grant order
`timescale 1ns/10ps
module ipc_mem_model
    import ipc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire ipc_fetch_t i_fetch,
    input wire logic i_slow,
    output logic o_gnt,
    output logic o_rvalid,
    output logic [31:0] o_rdata
);
    logic [31:0] q[$];
    logic ok_r;
    // grant in the request cycle; a slow memory serves every other cycle
    assign o_gnt = i_fetch.req & ok_r;
    // each word is the inverse of its address
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q.delete();
            ok_r <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            ok_r <= !i_slow || !ok_r;
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata; // no stale word between answers
            if (q.size() > 0 && ok_r) begin
                o_rvalid <= 1'b1;
                o_rdata <= ~q.pop_front();
            end
            if (o_gnt) begin
                q.push_back(i_fetch.addr);
            end
        end
    end
endmodule

// >>> tb/ipc_core_sva.sv
// assertions on the ports of the prefetch cache core
`timescale 1ns/10ps
module ipc_core_chk
    import ipc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire ipc_fetch_t o_fetch,
    input wire logic i_fetch_gnt,
    input wire logic i_fetch_rvalid,
    input wire ipc_branch_t i_branch,
    input wire logic i_frame_exec,
    input wire logic i_mem_exec,
    input wire logic i_sr_wr,
    input wire logic [31:0] i_sr_wdata,
    input wire logic o_cache_mode,
    input wire logic [31:0] o_look_ahead,
    input wire logic [31:0] o_look_back
);
    logic [2:0] pend_r;
    wire gnt = o_fetch.req & i_fetch_gnt;
    wire br = i_branch.taken;
    wire [31:0] la = o_look_ahead;
    wire [31:0] lb = o_look_back;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // words owed by memory, flushed ones included since memory still returns them
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_r <= 3'h0;
        end else begin
            pend_r <= pend_r + 3'(gnt) - 3'(i_fetch_rvalid);
        end
    end
    sequence s_hard_br;
        br && !i_branch.one_half;
    endsequence
    sequence s_reloaded;
        la == {$past(i_branch.target[31:2]), 2'h0} && lb == la;
    endsequence
    AST_ALIGN: assert property (o_fetch.req |-> o_fetch.addr[1:0] == 2'h0)
        else $error("prefetch address not word aligned");
    AST_TWO_PEND: assert property (gnt |-> pend_r < 3'h2)
        else $error("third prefetch granted");
    AST_AHEAD_LAST: assert property (gnt && !br |=> la == $past(o_fetch.addr))
        else $error("look ahead not last granted word");
    AST_AHEAD_STEP: assert property (!$past(br) && la != $past(la) |-> la == $past(la) + 4)
        else $error("look ahead step wrong");
    AST_BACK_STEP: assert property (!$past(br) && lb != $past(lb) |-> lb == $past(lb) + 4)
        else $error("look back step wrong");
    AST_SPAN: assert property (la - lb < 32'h88)
        else $error("window wider than buffer");
    AST_MEM_HOLD: assert property (i_mem_exec |=> !o_fetch.req)
        else $error("prefetch during memory cycle");
    AST_FLUSH: assert property (s_hard_br |=> s_reloaded)
        else $error("counters not reloaded on flush");
    AST_MODE_CLR: assert property ((br && !i_branch.delayed || i_frame_exec) && !i_sr_wr
        |=> !o_cache_mode)
        else $error("mode flag not cleared");
    AST_SR_WR: assert property (i_sr_wr |=> o_cache_mode == $past(i_sr_wdata[SR_M_BIT]))
        else $error("mode flag not written");
endmodule
bind ipc_core ipc_core_chk u_ipc_core_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .o_fetch(o_fetch), .i_fetch_gnt(i_fetch_gnt), .i_fetch_rvalid(i_fetch_rvalid),
    .i_branch(i_branch), .i_frame_exec(i_frame_exec), .i_mem_exec(i_mem_exec),
    .i_sr_wr(i_sr_wr), .i_sr_wdata(i_sr_wdata), .o_cache_mode(o_cache_mode),
    .o_look_ahead(o_look_ahead), .o_look_back(o_look_back));

// >>> tb/tb_instruction_prefetch_cache.sv
// self-checking bench of the prefetch cache core
`timescale 1ns/10ps
module tb_instruction_prefetch_cache;
    import ipc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic gnt, rvalid, mode, slow = 1'b0, frame = 1'b0, mem = 1'b0, sr_wr = 1'b0;
    logic [31:0] rdata, la, lb, pc = 32'h0, sr_wdata = 32'h0;
    logic [1:0] len = 2'h3;
    ipc_fetch_t fetch;
    ipc_branch_t br = '0;
    ipc_dec_t dec;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    ipc_core u_ipc_core (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_fetch(fetch),
        .i_fetch_gnt(gnt), .i_fetch_rvalid(rvalid), .i_fetch_rdata(rdata), .i_pc(pc),
        .i_instr_len(len), .i_branch(br), .i_frame_exec(frame), .i_mem_exec(mem),
        .i_sr_wr(sr_wr), .i_sr_wdata(sr_wdata), .o_dec(dec), .o_cache_mode(mode),
        .o_look_ahead(la), .o_look_back(lb));
    ipc_mem_model u_ipc_mem_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fetch(fetch),
        .i_slow(slow), .o_gnt(gnt), .o_rvalid(rvalid), .o_rdata(rdata));
    always #5 i_mclk = ~i_mclk;
    // a hang counts as a mismatch
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [47:0] e, input logic [47:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_val(what, {47'h0, e}, {47'h0, g});
    endtask
    // memory word at a is ~a, high half at the lower address
    function automatic logic [15:0] half(input logic [31:0] a);
        logic [31:0] w;
        w = ~{a[31:2], 2'h0};
        return a[1] ? w[15:0] : w[31:16];
    endfunction
    task automatic wait_la(input logic [31:0] e);
        for (int i = 0; i < 100 && la !== e; i++) begin
            @(posedge i_mclk);
            #1;
        end
        repeat (10) @(posedge i_mclk);
        #1;
        chk_val("look_ahead", 48'(e), 48'(la));
    endtask
    task automatic chk_dec(input logic [31:0] p);
        @(posedge i_mclk);
        pc <= p;
        repeat (2) @(posedge i_mclk);
        #1;
        for (int i = 0; i < 20 && dec.ready !== 1'b1; i++) begin
            @(posedge i_mclk);
            #1;
        end
        chk_bit("dec_ready", 1'b1, dec.ready);
        chk_val("dec_halves", {half(p), half(p + 2), half(p + 4)}, dec.halves);
    endtask
    task automatic set_mode(input logic v);
        @(posedge i_mclk);
        sr_wr <= 1'b1;
        sr_wdata <= {27'h0, v, 4'h0};
        @(posedge i_mclk);
        sr_wr <= 1'b0;
        #1;
        chk_bit("cache_mode", v, mode);
    endtask
    task automatic t_fill();
        #1;
        chk_val("look_ahead", 48'h0, 48'(la));
        chk_bit("cache_mode", 1'b0, mode);
        wait_la(32'h20);
        chk_val("look_back", 48'h0, 48'(lb));
        chk_dec(32'h1a);
    endtask
    task automatic t_wrap();
        @(posedge i_mclk);
        slow <= 1'b1;
        pc <= 32'h60;
        wait_la(32'h80);
        chk_val("look_back", 48'h4, 48'(lb));
        chk_dec(32'h7e);
    endtask
    task automatic t_mem();
        wait_la(32'h9c);
        @(posedge i_mclk);
        slow <= 1'b0;
        mem <= 1'b1;
        pc <= 32'ha0;
        repeat (10) @(posedge i_mclk);
        #1;
        chk_val("look_ahead", 48'h9c, 48'(la));
        @(posedge i_mclk);
        mem <= 1'b0;
        wait_la(32'hc0);
    endtask
    task automatic t_branch();
        set_mode(1'b1);
        @(posedge i_mclk);
        br <= '{1'b1, 1'b0, 1'b0, 32'h1002};
        pc <= 32'h1002;
        @(posedge i_mclk);
        br <= '0;
        #1;
        chk_val("look_back", 48'h1000, 48'(lb));
        chk_bit("dec_ready", 1'b0, dec.ready);
        chk_bit("cache_mode", 1'b0, mode);
        wait_la(32'h1020);
        chk_dec(32'h1002);
        set_mode(1'b1);
        @(posedge i_mclk);
        frame <= 1'b1;
        @(posedge i_mclk);
        frame <= 1'b0;
        #1;
        chk_bit("cache_mode", 1'b0, mode);
    endtask
    // short branches that keep the window, then a reset in mid run
    task automatic t_hold();
        @(posedge i_mclk);
        br <= '{1'b1, 1'b1, 1'b0, 32'h1028};
        @(posedge i_mclk);
        br <= '0;
        #1;
        chk_val("look_ahead", 48'h1020, 48'(la));
        chk_val("look_back", 48'h1000, 48'(lb));
        set_mode(1'b1);
        @(posedge i_mclk);
        br <= '{1'b1, 1'b1, 1'b1, 32'h1100};
        @(posedge i_mclk);
        br <= '0;
        #1;
        chk_val("look_back", 48'h1000, 48'(lb));
        chk_bit("cache_mode", 1'b1, mode);
        @(posedge i_mclk);
        len <= 2'h1;
        chk_dec(32'h101e);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        chk_val("look_ahead", 48'h0, 48'(la));
        chk_val("look_back", 48'h0, 48'(lb));
        chk_bit("fetch_req", 1'b0, fetch.req);
        chk_bit("cache_mode", 1'b0, mode);
        chk_bit("dec_ready", 1'b0, dec.ready);
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        pc <= 32'h0;
        len <= 2'h3;
        wait_la(32'h20);
    endtask
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_fill();
        t_wrap();
        t_mem();
        t_branch();
        t_hold();
        give_verdict();
    end
endmodule
